// ==== mdc_axis_sat.v ====
// Eight-bit two's complement saturation of one axis sample
module mdc_axis_sat #(
  parameter IN_W = 12
) (
  // Sample
  input  wire signed [IN_W-1:0] sample_in,
  output reg         [7:0]      sample_out
);
  always @* begin
    if (sample_in > $signed(12'sh07F))
      sample_out = 8'h7F;
    else if (sample_in < $signed(12'shF80))
      sample_out = 8'h80;
    else
      sample_out = sample_in[7:0];
  end
endmodule // mdc_axis_sat

// ==== mdc_defs.vh ====
// Register offsets, field positions, reset values and timing constants
`ifndef MDC_DEFS_VH
`define MDC_DEFS_VH
`define MDC_OFF_MODE      8'h16
`define MDC_OFF_CLEAR     8'h17
`define MDC_OFF_CTRL1     8'h18
`define MDC_OFF_CTRL2     8'h19
`define MDC_OFF_LVL_TH    8'h1A
`define MDC_OFF_PLS_TH    8'h1B
`define MDC_OFF_PLS_DUR   8'h1C
`define MDC_OFF_LATENCY   8'h1D
`define MDC_OFF_WINDOW    8'h1E
`define MDC_OFF_FLAGS     8'h20
`define MDC_RESET_VALUE   8'h00
`define MDC_MODE_STANDBY  2'h0
`define MDC_MODE_MEASURE  2'h1
`define MDC_MODE_LEVEL    2'h2
`define MDC_MODE_PULSE    2'h3
`define MDC_RANGE_8G      2'h0
`define MDC_RANGE_2G      2'h1
`define MDC_RANGE_4G      2'h2
`define MDC_ASSIGN_LP     2'h0
`define MDC_ASSIGN_PL     2'h1
`define MDC_ASSIGN_SD     2'h2
`define MDC_BIT_SELFTEST  4
`define MDC_BIT_3W        5
`define MDC_BIT_RDYPIN    6
`define MDC_BIT_CLR_A     0
`define MDC_BIT_CLR_B     1
`define MDC_BIT_SWAP      0
`define MDC_BIT_XDIS      3
`define MDC_BIT_TOPT      6
`define MDC_BIT_BW        7
`define MDC_BIT_LPOL      0
`define MDC_BIT_PPOL      1
`define MDC_BIT_DRV       2
`define MDC_DUR_STEP_US   500
`define MDC_LAT_STEP_US   1000
`define MDC_CLK_MHZ       250
`define MDC_AXI_OKAY      2'h0
`define MDC_AXI_SLVERR    2'h2
`endif

// ==== mdc_event_latch.v ====
// One latched detection event with set-over-clear priority
module mdc_event_latch (
  // Clock and reset
  input  wire aclk,
  input  wire aresetn,
  // Event
  input  wire set_in,
  input  wire clear_in,
  output reg  flag
);
  always @(posedge aclk) begin
    if (!aresetn)
      flag <= 1'b0;
    else if (set_in)
      flag <= 1'b1;
    else if (clear_in)
      flag <= 1'b0;
  end
endmodule // mdc_event_latch

// ==== mdc_host.sv ====
// Host bus master model that reaches the register bank
module mdc_host (
  // Clock
  input  wire         aclk,
  // Write channels
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  wire         s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  wire         s_axi_wready,
  input  wire         s_axi_bvalid,
  output logic        s_axi_bready,
  // Read channels
  output logic [7:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  wire         s_axi_arready,
  input  wire         s_axi_rvalid,
  output logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // One write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  // One read
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    r = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!r) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
endmodule // mdc_host

// ==== mdc_regs.v ====
// Motion detect configuration register bank with AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`include "mdc_defs.vh"
module mdc_regs #(
  parameter ADDR_W   = 8,
  parameter SAMPLE_W = 12
) (
  // Clock and reset
  input  wire                aclk,
  input  wire                aresetn,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0]   s_axi_awaddr,
  input  wire                s_axi_awvalid,
  output wire                s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]         s_axi_wdata,
  input  wire [3:0]          s_axi_wstrb,
  input  wire                s_axi_wvalid,
  output wire                s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]          s_axi_bresp,
  output reg                 s_axi_bvalid,
  input  wire                s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0]   s_axi_araddr,
  input  wire                s_axi_arvalid,
  output wire                s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]         s_axi_rdata,
  output reg  [1:0]          s_axi_rresp,
  output reg                 s_axi_rvalid,
  input  wire                s_axi_rready,
  // Detection engine events and data
  input  wire                level_event,
  input  wire                single_pulse_event,
  input  wire                double_pulse_event,
  input  wire [2:0]          level_axis_hits,
  input  wire [2:0]          pulse_axis_hits,
  input  wire                sample_ready,
  input  wire [3*SAMPLE_W-1:0] raw_samples,
  // Configuration outputs
  output reg  [1:0]          operating_mode,
  output reg  [1:0]          range_select,
  output reg                 self_test_on,
  output reg                 three_wire_select,
  output reg  [2:0]          axis_enable,
  output reg                 threshold_signed,
  output reg                 filter_bandwidth,
  output reg                 level_and_mode,
  output reg                 pulse_and_mode,
  output reg                 output_drive_strength,
  output reg  [7:0]          level_threshold_value,
  output reg  [6:0]          pulse_threshold_value,
  output reg  [17:0]         pulse_duration_us,
  output reg  [17:0]         latency_us,
  output reg  [17:0]         second_window_us,
  output reg  [2:0]          level_axis_flags,
  output reg  [2:0]          pulse_axis_flags,
  output reg  [23:0]         axis_data,
  // Event pins
  output reg                 event_line_a,
  output reg                 event_line_b
);
  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0] mode_control;
  reg  [7:0] interrupt_latch_clear;
  reg  [7:0] detection_control_one;
  reg  [7:0] detection_control_two;
  reg  [7:0] level_threshold;
  reg  [7:0] pulse_threshold;
  reg  [7:0] pulse_duration;
  reg  [7:0] latency_time;
  reg  [7:0] second_pulse_window;
  reg        aw_held;
  reg        w_held;
  reg  [ADDR_W-1:0] aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire        flag_a;
  wire        flag_b;
  wire        do_write;
  wire        clear_a;
  wire        clear_b;
  reg         set_a;
  reg         set_b;
  reg         next_a_is_level;
  reg         next_b_is_level;
  reg  [31:0] next_rdata;
  reg         next_rhit;
  wire [1:0]  event_assignment;
  wire [23:0] sat_data;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= {ADDR_W{1'b0}};
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MDC_AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= ({2'h0, aw_addr[7:2]} >= `MDC_OFF_MODE && {2'h0, aw_addr[7:2]} <= `MDC_OFF_WINDOW)
                        ? `MDC_AXI_OKAY : `MDC_AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Registers are indexed: byte address is four times the offset
  wire [7:0] w_index = {2'h0, aw_addr[7:2]};
  wire       w_lane  = w_strb[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_control          <= `MDC_RESET_VALUE;
      interrupt_latch_clear <= `MDC_RESET_VALUE;
      detection_control_one <= `MDC_RESET_VALUE;
      detection_control_two <= `MDC_RESET_VALUE;
      level_threshold       <= `MDC_RESET_VALUE;
      pulse_threshold       <= `MDC_RESET_VALUE;
      pulse_duration        <= `MDC_RESET_VALUE;
      latency_time          <= `MDC_RESET_VALUE;
      second_pulse_window   <= `MDC_RESET_VALUE;
    end else if (do_write && w_lane) begin
      case (w_index)
        `MDC_OFF_MODE:    mode_control          <= {1'b0, w_data[6:0]};
        `MDC_OFF_CLEAR:   interrupt_latch_clear <= {6'h00, w_data[1:0]};
        `MDC_OFF_CTRL1:   detection_control_one <= w_data[7:0];
        `MDC_OFF_CTRL2:   detection_control_two <= {5'h00, w_data[2:0]};
        `MDC_OFF_LVL_TH:  level_threshold       <= w_data[7:0];
        `MDC_OFF_PLS_TH:  pulse_threshold       <= w_data[7:0];
        `MDC_OFF_PLS_DUR: pulse_duration        <= w_data[7:0];
        `MDC_OFF_LATENCY: latency_time          <= w_data[7:0];
        `MDC_OFF_WINDOW:  second_pulse_window   <= w_data[7:0];
        default: begin
        end
      endcase
    end
  end

  // Clear strobes: a one written to a clear bit acts once; zero does nothing
  wire clr_write = do_write && w_lane && (w_index == `MDC_OFF_CLEAR);
  assign clear_a = clr_write && w_data[`MDC_BIT_CLR_A];
  assign clear_b = clr_write && w_data[`MDC_BIT_CLR_B];

  // ****************************************
  // Read path
  // ****************************************
  always @* begin
    next_rhit  = 1'b1;
    next_rdata = 32'h00000000;
    case ({2'h0, s_axi_araddr[7:2]})
      `MDC_OFF_MODE:    next_rdata[7:0] = mode_control;
      `MDC_OFF_CLEAR:   next_rdata[7:0] = interrupt_latch_clear;
      `MDC_OFF_CTRL1:   next_rdata[7:0] = detection_control_one;
      `MDC_OFF_CTRL2:   next_rdata[7:0] = detection_control_two;
      `MDC_OFF_LVL_TH:  next_rdata[7:0] = level_threshold;
      `MDC_OFF_PLS_TH:  next_rdata[7:0] = pulse_threshold;
      `MDC_OFF_PLS_DUR: next_rdata[7:0] = pulse_duration;
      `MDC_OFF_LATENCY: next_rdata[7:0] = latency_time;
      `MDC_OFF_WINDOW:  next_rdata[7:0] = second_pulse_window;
      `MDC_OFF_FLAGS:   next_rdata[7:0] = {flag_b, flag_a, pulse_axis_flags, level_axis_flags};
      default:          next_rhit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `MDC_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rhit ? `MDC_AXI_OKAY : `MDC_AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Configuration decode
  // ****************************************
  assign event_assignment = detection_control_one[2:1];

  always @(posedge aclk) begin
    if (!aresetn) begin
      operating_mode        <= `MDC_MODE_STANDBY;
      range_select          <= `MDC_RANGE_8G;
      self_test_on          <= 1'b0;
      three_wire_select     <= 1'b0;
      axis_enable           <= 3'h7;
      threshold_signed      <= 1'b0;
      filter_bandwidth      <= 1'b0;
      level_and_mode        <= 1'b0;
      pulse_and_mode        <= 1'b0;
      output_drive_strength <= 1'b0;
      level_threshold_value <= 8'h00;
      pulse_threshold_value <= 7'h00;
      pulse_duration_us     <= 18'h00000;
      latency_us            <= 18'h00000;
      second_window_us      <= 18'h00000;
    end else begin
      operating_mode        <= mode_control[1:0];
      range_select          <= mode_control[3:2];
      self_test_on          <= mode_control[`MDC_BIT_SELFTEST];
      three_wire_select     <= mode_control[`MDC_BIT_3W];
      axis_enable           <= ~detection_control_one[`MDC_BIT_XDIS+2:`MDC_BIT_XDIS];
      threshold_signed      <= detection_control_one[`MDC_BIT_TOPT];
      filter_bandwidth      <= detection_control_one[`MDC_BIT_BW];
      level_and_mode        <= detection_control_two[`MDC_BIT_LPOL];
      pulse_and_mode        <= detection_control_two[`MDC_BIT_PPOL];
      output_drive_strength <= detection_control_two[`MDC_BIT_DRV];
      level_threshold_value <= detection_control_one[`MDC_BIT_TOPT] ? level_threshold
                               : {1'b0, level_threshold[6:0]};
      pulse_threshold_value <= pulse_threshold[6:0];
      pulse_duration_us     <= pulse_duration * 18'd`MDC_DUR_STEP_US;
      latency_us            <= latency_time * 18'd`MDC_LAT_STEP_US;
      second_window_us      <= second_pulse_window * 18'd`MDC_LAT_STEP_US;
    end
  end

  // ****************************************
  // Event assignment and latches
  // ****************************************
  always @* begin
    next_a_is_level = 1'b0;
    next_b_is_level = 1'b0;
    set_a = 1'b0;
    set_b = 1'b0;
    case (event_assignment)
      `MDC_ASSIGN_LP: begin
        set_a = level_event;
        set_b = single_pulse_event;
        next_a_is_level = 1'b1;
      end
      `MDC_ASSIGN_PL: begin
        set_a = single_pulse_event;
        set_b = level_event;
        next_b_is_level = 1'b1;
      end
      `MDC_ASSIGN_SD: begin
        set_a = single_pulse_event;
        set_b = (second_pulse_window == 8'h00 || latency_time == 8'h00)
                ? single_pulse_event : double_pulse_event;
      end
      default: begin
      end
    endcase
  end

  mdc_event_latch u_latch_a (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .set_in   (set_a),
    .clear_in (clear_a),
    .flag     (flag_a)
  );

  mdc_event_latch u_latch_b (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .set_in   (set_b),
    .clear_in (clear_b),
    .flag     (flag_b)
  );

  // Per-axis source bits: set by hits, cleared by the clear owning that kind
  wire clr_level = (clear_a && next_a_is_level) || (clear_b && next_b_is_level);
  wire clr_pulse = (clear_a && !next_a_is_level) || (clear_b && !next_b_is_level);

  always @(posedge aclk) begin
    if (!aresetn) begin
      level_axis_flags <= 3'h0;
      pulse_axis_flags <= 3'h0;
    end else begin
      level_axis_flags <= (clr_level ? 3'h0 : level_axis_flags) | level_axis_hits;
      pulse_axis_flags <= (clr_pulse ? 3'h0 : pulse_axis_flags) | pulse_axis_hits;
    end
  end

  // ****************************************
  // Pin routing
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      event_line_a <= 1'b0;
      event_line_b <= 1'b0;
    end else begin
      event_line_a <= (detection_control_one[`MDC_BIT_SWAP] ? flag_b : flag_a)
                      | (sample_ready && !mode_control[`MDC_BIT_RDYPIN]);
      event_line_b <= detection_control_one[`MDC_BIT_SWAP] ? flag_a : flag_b;
    end
  end

  // ****************************************
  // Axis data saturation
  // ****************************************
  genvar ax;
  generate
    for (ax = 0; ax < 3; ax = ax + 1) begin : g_axis
      mdc_axis_sat #(
        .IN_W (SAMPLE_W)
      ) u_sat (
        .sample_in  (raw_samples[ax*SAMPLE_W +: SAMPLE_W]),
        .sample_out (sat_data[ax*8 +: 8])
      );
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn)
      axis_data <= 24'h000000;
    else
      axis_data <= sat_data;
  end
endmodule // mdc_regs

// ==== mdc_regs_assertions.sv ====
// Port checker for the motion detect register bank
module mdc_regs_assertions #(
  parameter ADDR_W   = 8,
  parameter SAMPLE_W = 12
) (
  // Clock and reset
  input wire                  aclk,
  input wire                  aresetn,
  // Bus handshakes
  input wire                  s_axi_awvalid,
  input wire                  s_axi_awready,
  input wire                  s_axi_wvalid,
  input wire                  s_axi_wready,
  input wire                  s_axi_bvalid,
  input wire                  s_axi_arvalid,
  input wire                  s_axi_arready,
  input wire                  s_axi_rvalid,
  // Engine side and outputs
  input wire [2:0]            level_axis_hits,
  input wire [3*SAMPLE_W-1:0] raw_samples,
  input wire [2:0]            axis_enable,
  input wire [2:0]            level_axis_flags,
  input wire [23:0]           axis_data,
  input wire                  event_line_a
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Saturate one axis to eight bits
  function automatic [7:0] sat(input logic signed [SAMPLE_W-1:0] v);
    if (v > 127) sat = 8'h7F;
    else if (v < -128) sat = 8'h80;
    else sat = v[7:0];
  endfunction
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read response missing");
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  reset_value_a: assert property ($rose(aresetn) |-> axis_enable == 3'h7 && !event_line_a)
    else $error("wrong value after reset");
  axis_sat_a: assert property ($past(aresetn) |-> axis_data == {sat($past(raw_samples[35:24])),
    sat($past(raw_samples[23:12])), sat($past(raw_samples[11:0]))})
    else $error("axis data not saturated sample");
  flag_cause_a: assert property (!(|(level_axis_flags & ~$past(level_axis_flags) & ~$past(level_axis_hits))))
    else $error("axis flag set without hit");
  flag_keep_a: assert property (|($past(level_axis_flags) & ~level_axis_flags) |->
    s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("axis flag dropped without clear write");
endmodule // mdc_regs_assertions

// ==== mdc_regs_tb.sv ====
// Self-checking bench for the motion detect register bank
`include "mdc_defs.vh"
module mdc_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, level_threshold_value;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, operating_mode, range_select;
  logic        level_event, single_pulse_event, double_pulse_event, sample_ready;
  logic [2:0]  level_axis_hits, pulse_axis_hits, axis_enable, level_axis_flags, pulse_axis_flags;
  logic [35:0] raw_samples;
  logic        self_test_on, three_wire_select, threshold_signed, filter_bandwidth, level_and_mode;
  logic        pulse_and_mode, output_drive_strength, event_line_a, event_line_b;
  logic [6:0]  pulse_threshold_value;
  logic [17:0] pulse_duration_us, latency_us, second_window_us;
  logic [23:0] axis_data;
  logic [33:0] exq[$];
  logic [7:0]  offs[9] = '{`MDC_OFF_MODE, `MDC_OFF_CLEAR, `MDC_OFF_CTRL1, `MDC_OFF_CTRL2,
    `MDC_OFF_LVL_TH, `MDC_OFF_PLS_TH, `MDC_OFF_PLS_DUR, `MDC_OFF_LATENCY, `MDC_OFF_WINDOW};
  logic [7:0]  msk[9] = '{8'h7F, 8'h03, 8'hFF, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [1:0]  exl[3] = '{2'b01, 2'b10, 2'b00};
  logic [1:0]  exs[3] = '{2'b10, 2'b01, 2'b11};
  integer      n_errors, check_count, seed, i, c;
  mdc_regs i_mdc_regs (.*);
  mdc_host i_mdc_host (.*);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [33:0] g, input logic [33:0] x);
    check_count++;
    if (g !== x) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [7:0] o, input logic [31:0] v, input logic [1:0] r = `MDC_AXI_OKAY);
    exq.push_back({r, 32'h0});
    i_mdc_host.wr({o[5:0], 2'b00}, v);
  endtask
  task automatic rd(input logic [7:0] o, input logic [31:0] v, input logic [1:0] r = `MDC_AXI_OKAY);
    exq.push_back({r, v});
    i_mdc_host.rd({o[5:0], 2'b00});
  endtask
  task automatic fire(input logic [2:0] k, input logic [2:0] lh, input logic [2:0] ph);
    @(posedge aclk);
    {double_pulse_event, single_pulse_event, level_event} <= k;
    {level_axis_hits, pulse_axis_hits} <= {lh, ph};
    @(posedge aclk);
    {double_pulse_event, single_pulse_event, level_event} <= 3'h0;
    {level_axis_hits, pulse_axis_hits} <= 6'h0;
    repeat (6) @(posedge aclk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Bus responses are compared in the order they were requested
  always @(negedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, exq.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exq.pop_front());
  end
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    seed = 32'h3018;
    {n_errors, check_count, aresetn, sample_ready, raw_samples} = '0;
    {double_pulse_event, single_pulse_event, level_event, level_axis_hits, pulse_axis_hits} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 9; i++) rd(offs[i], 32'h0);
    rd(`MDC_OFF_FLAGS, 32'h0);
    chk(34'(axis_enable), 34'h7);
    $display("test reset done");
    for (i = 0; i < 9; i++) begin
      d = $random(seed);
      if (i == 4 || i == 5) d[7] = 1'b0;
      raw_samples <= 36'({$random(seed), $random(seed)});
      wr(offs[i], d);
      rd(offs[i], {24'h0, d[7:0] & msk[i]});
    end
    wr(8'h1F, 32'h5A, `MDC_AXI_SLVERR);
    rd(8'h1F, 32'h0, `MDC_AXI_SLVERR);
    raw_samples <= {12'h005, 12'h800, 12'h7FF};
    repeat (2) @(posedge aclk);
    #1;
    chk(34'(axis_data), 34'h05807F);
    $display("test access done");
    for (c = 0; c < 12; c++) begin
      d = $random(seed);
      d[3:0] = {2'(c / 4), 2'(c % 4)};
      wr(`MDC_OFF_MODE, {25'h0, d[6:0]});
      @(posedge aclk);
      #1;
      chk(34'({three_wire_select, self_test_on, range_select, operating_mode}), 34'(d[5:0]));
    end
    repeat (4) begin
      d = $random(seed);
      wr(`MDC_OFF_CTRL1, {24'h0, d[7:0]});
      wr(`MDC_OFF_CTRL2, {29'h0, d[10:8]});
      @(posedge aclk);
      #1;
      chk(34'({filter_bandwidth, threshold_signed, axis_enable}), 34'({d[7:6], ~d[5:3]}));
      chk(34'({output_drive_strength, pulse_and_mode, level_and_mode}), 34'(d[10:8]));
    end
    for (c = 0; c < 2; c++) begin
      wr(`MDC_OFF_CTRL1, c ? 32'h40 : 32'h0);
      wr(`MDC_OFF_LVL_TH, c ? 32'h95 : 32'h15);
      wr(`MDC_OFF_PLS_TH, c ? 32'h7F : 32'h01);
      wr(`MDC_OFF_PLS_DUR, c ? 32'hFF : 32'h01);
      wr(`MDC_OFF_LATENCY, c ? 32'hFF : 32'h01);
      wr(`MDC_OFF_WINDOW, c ? 32'hFF : 32'h01);
      @(posedge aclk);
      #1;
      chk(34'({level_threshold_value, pulse_threshold_value}), c ? 34'({8'h95, 7'h7F}) : 34'({8'h15, 7'h01}));
      chk(34'(pulse_duration_us), 34'((c ? 255 : 1) * `MDC_DUR_STEP_US));
      chk(34'(latency_us), 34'((c ? 255 : 1) * `MDC_LAT_STEP_US));
      chk(34'(second_window_us), 34'((c ? 255 : 1) * `MDC_LAT_STEP_US));
    end
    $display("test decode done");
    wr(`MDC_OFF_MODE, 32'h40);
    wr(`MDC_OFF_LATENCY, 32'h0);
    wr(`MDC_OFF_WINDOW, 32'h0);
    for (c = 0; c < 3; c++) begin
      wr(`MDC_OFF_CTRL1, 32'(c << 1));
      fire(3'b001, 3'b101, 3'h0);
      chk(34'({event_line_b, event_line_a}), 34'(exl[c]));
      fire(3'b010, 3'h0, 3'b010);
      wr(`MDC_OFF_CLEAR, 32'h0);
      chk(34'({event_line_b, event_line_a}), 34'(exs[c] | exl[c]));
      wr(`MDC_OFF_CLEAR, 32'h3);
      @(posedge aclk);
      #1;
      chk(34'({event_line_b, event_line_a, pulse_axis_flags, level_axis_flags}), 34'(c == 2 ? 3'b101 : 3'b000));
    end
    wr(`MDC_OFF_CTRL1, 32'h0);
    fire(3'b001, 3'b101, 3'h0);
    fire(3'b010, 3'h0, 3'b010);
    rd(`MDC_OFF_FLAGS, 32'hD5);
    wr(`MDC_OFF_CTRL1, 32'h1);
    wr(`MDC_OFF_CLEAR, 32'h1);
    rd(`MDC_OFF_FLAGS, 32'h90);
    chk(34'({event_line_b, event_line_a}), 34'h1);
    wr(`MDC_OFF_CLEAR, 32'h2);
    rd(`MDC_OFF_FLAGS, 32'h0);
    wr(`MDC_OFF_CTRL1, 32'h4);
    wr(`MDC_OFF_LATENCY, 32'h1);
    wr(`MDC_OFF_WINDOW, 32'h1);
    fire(3'b010, 3'h0, 3'b001);
    chk(34'({event_line_b, event_line_a}), 34'h1);
    fire(3'b100, 3'h0, 3'b001);
    chk(34'({event_line_b, event_line_a}), 34'h3);
    wr(`MDC_OFF_CLEAR, 32'h3);
    wr(`MDC_OFF_MODE, 32'h0);
    sample_ready <= 1'b1;
    repeat (3) @(posedge aclk);
    #1;
    chk(34'(event_line_a), 34'h1);
    wr(`MDC_OFF_MODE, 32'h40);
    repeat (2) @(posedge aclk);
    #1;
    chk(34'(event_line_a), 34'h0);
    $display("test events done");
    chk(34'(exq.size()), 34'h0);
    tally_and_finish();
  end
endmodule // mdc_regs_tb
bind mdc_regs mdc_regs_assertions #(.ADDR_W(ADDR_W), .SAMPLE_W(SAMPLE_W)) i_mdc_regs_assertions (.*);
